// ===== core/epp_dev.sv
`timescale 1ns/1ps
module epp_dev (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    epp_if.dev_mp                              pins,
    input  wire logic [epp_pkg::ADDR_W-1:0]    logic_addr,
    output logic      [epp_pkg::WORD_W-1:0]    logic_word,
    output logic      [epp_pkg::ARCH_W-1:0]    arch_bits,
    output logic                               prog_mode,
    output logic                               test_mode,
    output logic                               secured
);
    import epp_pkg::*;

    localparam int SYNC_W = 4 + ADDR_W + WORD_W;

    typedef enum logic [3:0] {
        DS_NORMAL  = 4'b0001,
        DS_INHIBIT = 4'b0010,
        DS_VERIFY  = 4'b0100,
        DS_WRITE   = 4'b1000
    } epp_dstate_e;

    epp_dstate_e        state_q;
    epp_dstate_e        state_d;
    logic               s_vpp;
    logic               s_test;
    logic               s_rw_super;
    logic               s_rw_level;
    logic [ADDR_W-1:0]  s_addr;
    logic [WORD_W-1:0]  s_data;
    logic               test_sel_q;
    logic [WORD_W-1:0]  main_q [NUM_LOC];
    logic [WORD_W-1:0]  test_q [TEST_LOC];
    logic [WORD_W-1:0]  rd_word;
    logic               sec_cell;
    logic [WORD_W-1:0]  dev_data_q;
    logic               dev_oe_n_q;

    function automatic logic [WORD_W-1:0] epp_pin_val(
        input logic [WORD_W-1:0] cells
    );
        return ~cells;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    epp_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      ({pins.vpp_super, pins.test_super, pins.rw_super,
                  pins.rw_level, pins.addr, pins.pin_data}),
        .q      ({s_vpp, s_test, s_rw_super, s_rw_level,
                  s_addr, s_data})
    );

    // ------------------------------------------------------------
    // access mode decode
    // ------------------------------------------------------------
    always_comb
    begin
        if (!s_vpp)
        begin
            state_d = DS_NORMAL;
        end
        else if (s_rw_super)
        begin
            state_d = DS_WRITE;
        end
        else if (s_rw_level)
        begin
            state_d = DS_INHIBIT;
        end
        else
        begin
            state_d = DS_VERIFY;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_q <= DS_NORMAL;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // test array selection, latched at mode entry
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            test_sel_q <= 1'b0;
        end
        else if (!s_vpp)
        begin
            test_sel_q <= 1'b0;
        end
        else if (state_q == DS_NORMAL)
        begin
            test_sel_q <= s_test;
        end
    end

    // ------------------------------------------------------------
    // cell arrays, reset models an erased part
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_LOC; i++)
            begin
                main_q[i] <= CELL_ERASED;
            end
        end
        else if (state_q == DS_WRITE && !test_sel_q)
        begin
            main_q[s_addr] <= main_q[s_addr] | s_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < TEST_LOC; i++)
            begin
                test_q[i] <= CELL_ERASED;
            end
        end
        else if (state_q == DS_WRITE && test_sel_q)
        begin
            test_q[s_addr[TEST_AW-1:0]] <=
                test_q[s_addr[TEST_AW-1:0]] | s_data;
        end
    end

    // ------------------------------------------------------------
    // verify read path
    // ------------------------------------------------------------
    assign rd_word  = test_sel_q ? test_q[s_addr[TEST_AW-1:0]]
                                 : main_q[s_addr];
    assign sec_cell = main_q[SEC_ADDR][SEC_BIT];

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            dev_oe_n_q <= 1'b1;
        end
        else
        begin
            dev_oe_n_q <= !(state_q == DS_VERIFY && !sec_cell);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            dev_data_q <= READ_BLANK;
        end
        else if (state_q == DS_VERIFY && !sec_cell)
        begin
            dev_data_q <= epp_pin_val(rd_word);
        end
        else
        begin
            dev_data_q <= READ_BLANK;
        end
    end

    assign pins.dev_data = dev_data_q;
    assign pins.dev_oe_n = dev_oe_n_q;

    // ------------------------------------------------------------
    // logic-side view of the configuration
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            logic_word <= CELL_ERASED;
        end
        else if (test_sel_q)
        begin
            logic_word <= test_q[logic_addr[TEST_AW-1:0]];
        end
        else
        begin
            logic_word <= main_q[logic_addr];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            arch_bits <= '0;
        end
        else
        begin
            arch_bits <= main_q[ARCH_ADDR][ARCH_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            prog_mode <= 1'b0;
            test_mode <= 1'b0;
            secured   <= 1'b0;
        end
        else
        begin
            prog_mode <= (state_q != DS_NORMAL);
            test_mode <= test_sel_q;
            secured   <= sec_cell;
        end
    end

endmodule

// ===== core/epp_pkg.sv
package epp_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int WORD_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int NUM_LOC  = 256;
    localparam int TEST_AW  = 4;
    localparam int TEST_LOC = 16;
    localparam int ARCH_W   = 5;
    localparam int SEC_BIT  = 0;
    localparam int CNT_W    = 8;

    localparam logic [ADDR_W-1:0] ARCH_ADDR = 8'hFE;
    localparam logic [ADDR_W-1:0] SEC_ADDR  = 8'hFF;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 8'hFF;
    localparam logic [ADDR_W-1:0] FIRST_ADDR = 8'h00;

    // ------------------------------------------------------------
    // cell values (stored 1 = programmed, pins read 1 = unprogrammed)
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] CELL_ERASED = 8'h00;
    localparam logic [WORD_W-1:0] READ_BLANK  = 8'hFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 40;
    localparam int MODE_ENTRY_NS  = 200;
    localparam int DATA_SETUP_NS  = 80;
    localparam int WRITE_PULSE_NS = 400;
    localparam int RECOVER_NS     = 80;
    localparam int READ_SETTLE_NS = 320;

    function automatic int epp_cycles(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [CNT_W-1:0] ENTRY_CYC   =
        CNT_W'(epp_cycles(MODE_ENTRY_NS));
    localparam logic [CNT_W-1:0] SETUP_CYC   =
        CNT_W'(epp_cycles(DATA_SETUP_NS));
    localparam logic [CNT_W-1:0] PULSE_CYC   =
        CNT_W'(epp_cycles(WRITE_PULSE_NS));
    localparam logic [CNT_W-1:0] RECOVER_CYC =
        CNT_W'(epp_cycles(RECOVER_NS));
    localparam logic [CNT_W-1:0] SETTLE_CYC  =
        CNT_W'(epp_cycles(READ_SETTLE_NS));

    // ------------------------------------------------------------
    // host commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_PROG    = 3'h0,
        CMD_VERIFY  = 3'h1,
        CMD_BLANK   = 3'h2,
        CMD_TPROG   = 3'h3,
        CMD_TVERIFY = 3'h4
    } epp_cmd_e;

endpackage

// ===== core/epp_if.sv
`timescale 1ns/1ps
interface epp_if;
    import epp_pkg::*;

    logic              vpp_super;
    logic              test_super;
    logic              rw_super;
    logic              rw_level;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] host_data;
    logic              host_oe_n;
    logic [WORD_W-1:0] dev_data;
    logic              dev_oe_n;
    logic [WORD_W-1:0] pin_data;

    // ------------------------------------------------------------
    // shared data pins, pulled high when nobody drives
    // ------------------------------------------------------------
    assign pin_data = !dev_oe_n  ? dev_data  :
                      !host_oe_n ? host_data : READ_BLANK;

    modport dev_mp (
        input  vpp_super,
        input  test_super,
        input  rw_super,
        input  rw_level,
        input  addr,
        input  pin_data,
        output dev_data,
        output dev_oe_n
    );

    modport host_mp (
        output vpp_super,
        output test_super,
        output rw_super,
        output rw_level,
        output addr,
        output host_data,
        output host_oe_n,
        input  pin_data
    );

endinterface

// ===== core/epp_sync.sv
`timescale 1ns/1ps
module epp_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // two-stage pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ===== core/epp_host.sv
`timescale 1ns/1ps
module epp_host (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    epp_if.host_mp                             pins,
    input  wire logic                          cmd_valid,
    input  wire epp_pkg::epp_cmd_e             cmd_op,
    input  wire logic [epp_pkg::ADDR_W-1:0]    cmd_addr,
    input  wire logic [epp_pkg::WORD_W-1:0]    cmd_data,
    output logic                               cmd_ready,
    output logic                               rsp_valid,
    output logic      [epp_pkg::WORD_W-1:0]    rsp_data,
    output logic                               rsp_ok
);
    import epp_pkg::*;

    typedef enum logic [6:0] {
        H_IDLE    = 7'b0000001,
        H_ENTER   = 7'b0000010,
        H_DRIVE   = 7'b0000100,
        H_PULSE   = 7'b0001000,
        H_RECOVER = 7'b0010000,
        H_READ    = 7'b0100000,
        H_EXIT    = 7'b1000000
    } epp_hstate_e;

    epp_hstate_e        st_q;
    epp_cmd_e           op_q;
    logic [CNT_W-1:0]   tmr_q;
    logic [WORD_W-1:0]  wdata_q;
    logic [WORD_W-1:0]  s_data;
    logic               is_write;

    assign is_write = (op_q == CMD_PROG) || (op_q == CMD_TPROG);

    epp_sync #(
        .W (WORD_W)
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (pins.pin_data),
        .q      (s_data)
    );

    // ------------------------------------------------------------
    // programming sequencer, delays are parameters of the part
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            st_q            <= H_IDLE;
            op_q            <= CMD_VERIFY;
            tmr_q           <= '0;
            wdata_q         <= '0;
            pins.vpp_super  <= 1'b0;
            pins.test_super <= 1'b0;
            pins.rw_super   <= 1'b0;
            pins.rw_level   <= 1'b1;
            pins.addr       <= '0;
            pins.host_data  <= '0;
            pins.host_oe_n  <= 1'b1;
            cmd_ready       <= 1'b1;
            rsp_valid       <= 1'b0;
            rsp_data        <= '0;
            rsp_ok          <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (tmr_q != '0)
            begin
                tmr_q <= tmr_q - 1'b1;
            end
            unique case (st_q)
                H_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        op_q            <= cmd_op;
                        wdata_q         <= cmd_data;
                        pins.addr       <= (cmd_op == CMD_BLANK) ?
                                           FIRST_ADDR : cmd_addr;
                        pins.vpp_super  <= 1'b1;
                        pins.test_super <= (cmd_op == CMD_TPROG) ||
                                           (cmd_op == CMD_TVERIFY);
                        pins.rw_level   <= 1'b1;
                        rsp_ok          <= 1'b1;
                        cmd_ready       <= 1'b0;
                        tmr_q           <= ENTRY_CYC;
                        st_q            <= H_ENTER;
                    end
                end
                H_ENTER:
                begin
                    if (tmr_q == '0 && is_write)
                    begin
                        pins.host_data <= wdata_q;
                        pins.host_oe_n <= 1'b0;
                        tmr_q          <= SETUP_CYC;
                        st_q           <= H_DRIVE;
                    end
                    else if (tmr_q == '0)
                    begin
                        pins.rw_level <= 1'b0;
                        tmr_q         <= SETTLE_CYC;
                        st_q          <= H_READ;
                    end
                end
                H_DRIVE:
                begin
                    if (tmr_q == '0)
                    begin
                        pins.rw_super <= 1'b1;
                        tmr_q         <= PULSE_CYC;
                        st_q          <= H_PULSE;
                    end
                end
                H_PULSE:
                begin
                    if (tmr_q == '0)
                    begin
                        pins.rw_super <= 1'b0;
                        tmr_q         <= RECOVER_CYC;
                        st_q          <= H_RECOVER;
                    end
                end
                H_RECOVER:
                begin
                    if (tmr_q == '0)
                    begin
                        pins.host_oe_n <= 1'b1;
                        pins.rw_level  <= 1'b0;
                        tmr_q          <= SETTLE_CYC;
                        st_q           <= H_READ;
                    end
                end
                H_READ:
                begin
                    if (tmr_q == '0)
                    begin
                        rsp_data <= s_data;
                        if (op_q == CMD_BLANK)
                        begin
                            rsp_ok <= rsp_ok && (s_data == READ_BLANK);
                        end
                        else if (is_write)
                        begin
                            rsp_ok <= ((~s_data & wdata_q) == wdata_q);
                        end
                        if (op_q == CMD_BLANK && pins.addr != LAST_ADDR)
                        begin
                            pins.addr <= pins.addr + 1'b1;
                            tmr_q     <= SETTLE_CYC;
                        end
                        else
                        begin
                            pins.rw_level   <= 1'b1;
                            pins.vpp_super  <= 1'b0;
                            pins.test_super <= 1'b0;
                            tmr_q           <= ENTRY_CYC;
                            st_q            <= H_EXIT;
                        end
                    end
                end
                H_EXIT:
                begin
                    if (tmr_q == '0)
                    begin
                        rsp_valid <= 1'b1;
                        cmd_ready <= 1'b1;
                        st_q      <= H_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// ===== testbench/epp_monitor.sv
`timescale 1ns/1ps
module epp_monitor (
    input wire logic                       mclk,
    input wire logic                       resetn,
    input wire logic                       vpp_super,
    input wire logic                       test_super,
    input wire logic                       rw_super,
    input wire logic                       rw_level,
    input wire logic [epp_pkg::ADDR_W-1:0] addr,
    input wire logic [epp_pkg::WORD_W-1:0] host_data,
    input wire logic                       host_oe_n,
    input wire logic                       dev_oe_n
);
    import epp_pkg::*;

    // ------------------------------------------------------------
    // pin protocol checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    no_contention_a: assert property (
        !(!dev_oe_n && !host_oe_n))
        else $error("both ends drive the data pins");
    read_entry_a: assert property (
        $fell(dev_oe_n) |-> $past(vpp_super, 2) && !$past(rw_level, 2))
        else $error("device drove pins without a verify request");
    inhibit_float_a: assert property (
        $rose(rw_level) |-> ##[1:6] dev_oe_n)
        else $error("pins not floated after inhibit");
    vpp_off_float_a: assert property (
        !vpp_super [*6] |-> dev_oe_n)
        else $error("device drives pins outside programming mode");
    write_hold_a: assert property (
        rw_super |-> !host_oe_n && vpp_super && $stable(addr)
                     && $stable(host_data))
        else $error("write pulse without stable data and address");
    write_setup_a: assert property (
        $rose(rw_super) |-> !$past(host_oe_n, 2)
                            && $past(host_data, 2) == host_data)
        else $error("write data not set up before pulse");
    write_pulse_a: assert property (
        $rose(rw_super) |-> rw_super [*8])
        else $error("write pulse too short");
    write_release_a: assert property (
        $fell(rw_super) |-> !host_oe_n && $stable(host_data))
        else $error("write data dropped with the pulse");
    test_latch_a: assert property (
        vpp_super && $past(vpp_super) |-> $stable(test_super))
        else $error("test select changed inside a session");
    no_idle_write_a: assert property (
        !vpp_super |-> !rw_super)
        else $error("write supervoltage outside programming mode");
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import epp_pkg::*;

    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic              mclk       = 1'b0;
    logic              resetn     = 1'b0;
    logic              cmd_valid  = 1'b0;
    epp_cmd_e          cmd_op     = CMD_VERIFY;
    logic [ADDR_W-1:0] cmd_addr   = 8'h00;
    logic [WORD_W-1:0] cmd_data   = 8'h00;
    logic [ADDR_W-1:0] logic_addr = 8'h00;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [WORD_W-1:0] rsp_data;
    logic              rsp_ok;
    logic [WORD_W-1:0] logic_word;
    logic [ARCH_W-1:0] arch_bits;
    logic              prog_mode;
    logic              test_mode;
    logic              secured;
    logic [WORD_W-1:0] rd;
    logic              ok;
    logic              saw_prog;
    logic              saw_test;
    int                n_errors  = 0;
    int                cmp_count = 0;
    int                cycles    = 0;

    always #20 mclk = ~mclk;

    epp_if epp_if_i ();

    epp_host epp_host_i (
        .mclk(mclk), .resetn(resetn), .pins(epp_if_i),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ok(rsp_ok)
    );

    epp_dev epp_dev_i (
        .mclk(mclk), .resetn(resetn), .pins(epp_if_i),
        .logic_addr(logic_addr), .logic_word(logic_word),
        .arch_bits(arch_bits), .prog_mode(prog_mode),
        .test_mode(test_mode), .secured(secured)
    );

    epp_monitor epp_monitor_i (
        .mclk(mclk), .resetn(resetn),
        .vpp_super(epp_if_i.vpp_super), .test_super(epp_if_i.test_super),
        .rw_super(epp_if_i.rw_super), .rw_level(epp_if_i.rw_level),
        .addr(epp_if_i.addr), .host_data(epp_if_i.host_data),
        .host_oe_n(epp_if_i.host_oe_n), .dev_oe_n(epp_if_i.dev_oe_n)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] inv(input logic [7:0] c);
        return ~c;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_cmd(input epp_cmd_e op, input logic [7:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        check(cmd_ready, 1'b0);
        saw_prog = 1'b0;
        saw_test = 1'b0;
        while (rsp_valid !== 1'b1 && n < 4000)
        begin
            if (prog_mode === 1'b1)
                saw_prog = 1'b1;
            if (test_mode === 1'b1)
                saw_test = 1'b1;
            @(negedge mclk);
            n++;
        end
        check(rsp_valid, 1'b1);
        check(cmd_ready, 1'b1);
        check(saw_prog, 1'b1);
        rd = rsp_data;
        ok = rsp_ok;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        check(prog_mode, 1'b0);
        check(test_mode, 1'b0);
        check({secured, arch_bits}, 6'h00);
        check(epp_if_i.dev_oe_n, 1'b1);
        do_cmd(CMD_BLANK, 8'h00, 8'h00);
        check(ok, 1'b1);
        do_cmd(CMD_VERIFY, 8'h10, 8'h00);
        check(rd, READ_BLANK);
        do_cmd(CMD_PROG, 8'h10, 8'hA5);
        check(ok, 1'b1);
        do_cmd(CMD_VERIFY, 8'h10, 8'h00);
        check(rd, inv(8'hA5));
        do_cmd(CMD_PROG, 8'h10, 8'h0F);
        check(ok, 1'b1);
        do_cmd(CMD_VERIFY, 8'h10, 8'h00);
        check(rd, inv(8'hAF));
        do_cmd(CMD_VERIFY, 8'h11, 8'h00);
        check(rd, READ_BLANK);
        do_cmd(CMD_BLANK, 8'h00, 8'h00);
        check(ok, 1'b0);
        do_cmd(CMD_TPROG, 8'h03, 8'h3C);
        check(saw_test, 1'b1);
        do_cmd(CMD_TVERIFY, 8'h03, 8'h00);
        check(rd, inv(8'h3C));
        do_cmd(CMD_VERIFY, 8'h03, 8'h00);
        check({saw_test, rd}, {1'b0, READ_BLANK});
        logic_addr = 8'h10;
        repeat (3) @(negedge mclk);
        check(logic_word, 8'hAF);
        logic_addr = 8'h03;
        repeat (3) @(negedge mclk);
        check(logic_word, 8'h00);
        do_cmd(CMD_PROG, ARCH_ADDR, 8'h15);
        check(arch_bits, 5'h15);
        do_cmd(CMD_VERIFY, ARCH_ADDR, 8'h00);
        check(rd, inv(8'h15));
        do_cmd(CMD_PROG, SEC_ADDR, 8'h01);
        check(secured, 1'b1);
        check(ok, 1'b0);
        do_cmd(CMD_VERIFY, 8'h10, 8'h00);
        check(rd, READ_BLANK);
        do_cmd(CMD_TVERIFY, 8'h03, 8'h00);
        check(rd, READ_BLANK);
        finish_test();
    end
endmodule
